// ### rtl/crs_gpr_array.sv
// crs_gpr_array: sixteen 32-bit general registers, registered read port
// assumes: write and read indexes come from the same clock domain
`timescale 1ns/1ns
module crs_gpr_array (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic arst_n,
  // carrier
  crs_gpr_if.array  gpr
);
  // ************************************************
  // storage
  // ************************************************
  logic [31:0] regs_reg  [crs_pkg::NUM_GPR];  // register contents
  logic [31:0] regs_next [crs_pkg::NUM_GPR];  // next contents
  logic [31:0] rd_reg;                        // read data register
  logic [31:0] rd_next;                       // next read data

  // write decode and read select; write-through keeps reads current
  always_comb begin
    for (int i = 0; i < crs_pkg::NUM_GPR; i++) begin
      regs_next[i] = regs_reg[i];
    end
    if (gpr.wrEn) begin
      regs_next[gpr.wrIdx] = gpr.wrData;
    end
    rd_next = regs_next[gpr.rdIdx];
  end

  // register only
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < crs_pkg::NUM_GPR; i++) begin
        regs_reg[i] <= crs_pkg::WORD_RESET;
      end
      rd_reg <= crs_pkg::WORD_RESET;
    end else begin
      regs_reg <= regs_next;
      rd_reg   <= rd_next;
    end
  end

  assign gpr.rdData  = rd_reg;
  assign gpr.spValue = regs_reg[crs_pkg::SP_INDEX];
endmodule

// ### rtl/crs_gpr_if.sv
// crs_gpr_if: write/read carrier between the top and the register array
// assumes: driven by crs_register_set on clk_sys
`timescale 1ns/1ns
interface crs_gpr_if;
  logic        wrEn;     // write strobe
  logic [3:0]  wrIdx;    // write index
  logic [31:0] wrData;   // write data
  logic [3:0]  rdIdx;    // read index
  logic [31:0] rdData;   // registered read data
  logic [31:0] spValue;  // live slot zero, for stack use
  modport owner (output wrEn, wrIdx, wrData, rdIdx, input rdData, spValue);
  modport array (input wrEn, wrIdx, wrData, rdIdx, output rdData, spValue);
endinterface

// ### rtl/crs_pkg.sv
// crs_pkg: constants shared by the cpu register set
// assumes: one clock at 100 MHz, async active-low reset
package crs_pkg;
  // ************************************************
  // widths and counts
  // ************************************************
  localparam int unsigned DATA_W   = 32;             // register width
  localparam int unsigned NUM_GPR  = 16;             // general registers
  localparam int unsigned IDX_W    = 4;              // register index width
  localparam int unsigned SP_INDEX = 0;              // stack pointer slot
  // ************************************************
  // status word field positions
  // ************************************************
  localparam int unsigned PSW_C    = 0;              // carry
  localparam int unsigned PSW_Z    = 1;              // zero
  localparam int unsigned PSW_S    = 2;              // sign
  localparam int unsigned PSW_O    = 3;              // overflow
  localparam int unsigned PSW_I    = 16;             // interrupt enable
  localparam int unsigned PSW_U    = 17;             // stack select
  localparam int unsigned PSW_PM   = 20;             // privilege mode
  localparam int unsigned PSW_IPL  = 24;             // priority mask low bit
  localparam int unsigned IPL_W    = 4;              // priority mask width
  localparam int unsigned FLOAT_STATUS_WORD_OV  = 2;              // float overflow flag
  localparam int unsigned FLOAT_STATUS_WORD_OVE = 10;             // float overflow trap enable
  // ************************************************
  // values after reset
  // ************************************************
  localparam logic [31:0] PSW_RESET  = 32'h0000_0000;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [31:0] FLOAT_STATUS_WORD_RESET = 32'h0000_0100;
  // control register selectors
  typedef enum logic [2:0] {
    CRS_CR_PSW  = 3'b000,
    CRS_CR_USP  = 3'b001,
    CRS_CR_ISP  = 3'b010,
    CRS_CR_VTB  = 3'b011,
    CRS_CR_FLOAT_STATUS_WORD = 3'b100,
    CRS_CR_FVA  = 3'b101,
    CRS_CR_FSPC = 3'b110,
    CRS_CR_FSST = 3'b111
  } crs_ctrl_sel_t;
endpackage

// ### rtl/crs_register_set.sv
// crs_register_set: cpu register set, status word and interrupt gating
// assumes: datapath and interrupt controller on clk_sys, no outside pins
//
// Function
// - sixteen 32-bit general registers, read and write
// - register zero is the active stack pointer
// - two stack pointers, status bit selects one
// - vector table base register for ordinary vectors
// - fast interrupt saves pc and status
// - single saved context, nesting overwrites it
// - fast interrupt branches to fast vector address
// - float overflow sets float status flag
// - float overflow optionally raises exception
// - carry, zero, sign, overflow flags from arithmetic
// - carry reads one when carry occurred
// - four-bit priority mask, zero to fifteen
// - accept only priority above mask
// - interrupt enable bit gates acceptance
// - enable resets zero, clears on exception
// - stack select clears on exception
// - privilege mode clears on exception
`timescale 1ns/1ns
module crs_register_set (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // general register port
  input  wire logic        gprWrEn,
  input  wire logic [3:0]  gprWrIdx,
  input  wire logic [31:0] gprWrData,
  input  wire logic [3:0]  gprRdIdx,
  output logic      [31:0] gprRdData,
  // stack pointer update
  input  wire logic        spWrEn,
  input  wire logic [31:0] spWrData,
  output logic      [31:0] stackPointer,
  // control register access
  input  wire logic        ctrlWrEn,
  input  wire logic [2:0]  ctrlSel,
  input  wire logic [31:0] ctrlWrData,
  output logic      [31:0] ctrlRdData,
  // arithmetic flags
  input  wire logic        flagWrEn,
  input  wire logic [3:0]  flagIn,
  // float unit
  input  wire logic        floatOverflow,
  output logic             floatException,
  // interrupt controller
  input  wire logic        irqReq,
  input  wire logic [3:0]  irqLevel,
  input  wire logic        irqFast,
  output logic             irqAccept,
  output logic             irqAcceptFast,
  // exception entry and fast return
  input  wire logic        excAccept,
  input  wire logic [31:0] curPc,
  input  wire logic        fastReturn,
  output logic             pcLoadEn,
  output logic      [31:0] pcLoadValue,
  // status view
  output logic      [31:0] processorStatusWord,
  output logic      [31:0] vectorTableBase
);
  // ************************************************
  // control state
  // ************************************************
  logic [31:0] pswReg,  pswNext;   // processor_status_word
  logic [31:0] uspReg,  uspNext;   // user_stack_pointer (shadow)
  logic [31:0] ispReg,  ispNext;   // interrupt_stack_pointer (shadow)
  logic [31:0] vtbReg,  vtbNext;   // vector_table_base
  logic [31:0] fpswReg, fpswNext;  // float_status_word
  logic [31:0] fvaReg,  fvaNext;   // fast_vector_address
  logic [31:0] fspcReg, fspcNext;  // fast_saved_pc
  logic [31:0] fsstReg, fsstNext;  // fast_saved_status
  logic        accReg,  accNext;   // irq accepted pulse
  logic        accFReg, accFNext;  // fast irq accepted pulse
  logic        fexReg,  fexNext;   // float exception pulse
  logic        pcLdReg, pcLdNext;  // pc load pulse
  logic [31:0] pcValReg, pcValNext;// pc load value
  logic [31:0] rdReg,   rdNext;    // control read data
  logic        takeIrq;            // interrupt accepted this cycle
  logic        entry;              // any exception entry
  logic        selUser;            // current stack select
  logic        swapSp;             // select bit changes
  logic [31:0] pswAfter;           // status after software and flags
  logic [31:0] spOut;              // pointer leaving slot zero on a swap
  logic        liveWr;             // control write aimed at the active pointer

  // ************************************************
  // general registers, slot zero is the live stack pointer
  // ************************************************
  crs_gpr_if gpr ();

  crs_gpr_array u_array (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .gpr     (gpr)
  );

  // ************************************************
  // interrupt gating
  // ************************************************
  // strict compare: equal level is held off by the mask
  always_comb begin
    takeIrq = irqReq && pswReg[crs_pkg::PSW_I]
              && (irqLevel > pswReg[crs_pkg::PSW_IPL +: crs_pkg::IPL_W]);
    entry   = takeIrq || excAccept;
  end

  // ************************************************
  // status word and control registers
  // ************************************************
  // priority: entry over flag update over software write
  always_comb begin
    selUser  = pswReg[crs_pkg::PSW_U]; // stack select before this edge
    pswAfter = pswReg;
    uspNext  = uspReg;
    ispNext  = ispReg;
    vtbNext  = vtbReg;
    fpswNext = fpswReg;
    fvaNext  = fvaReg;
    fspcNext = fspcReg;
    fsstNext = fsstReg;
    if (ctrlWrEn) begin
      case (crs_pkg::crs_ctrl_sel_t'(ctrlSel))
        crs_pkg::CRS_CR_PSW:  pswAfter = ctrlWrData;
        crs_pkg::CRS_CR_USP:  uspNext  = ctrlWrData;
        crs_pkg::CRS_CR_ISP:  ispNext  = ctrlWrData;
        crs_pkg::CRS_CR_VTB:  vtbNext  = ctrlWrData;
        crs_pkg::CRS_CR_FLOAT_STATUS_WORD: fpswNext = ctrlWrData;
        crs_pkg::CRS_CR_FVA:  fvaNext  = ctrlWrData;
        crs_pkg::CRS_CR_FSPC: fspcNext = ctrlWrData;
        crs_pkg::CRS_CR_FSST: fsstNext = ctrlWrData;
        default:              pswAfter = pswReg;
      endcase
    end
    if (flagWrEn) begin
      pswAfter[crs_pkg::PSW_O:crs_pkg::PSW_C] = flagIn;
    end
    // overflow sets the flag even against a software clear
    if (floatOverflow) begin
      fpswNext[crs_pkg::FLOAT_STATUS_WORD_OV] = 1'b1;
    end
    pswNext = pswAfter;
    if (fastReturn) begin
      pswNext = fsstReg;
    end
    if (entry) begin
      pswNext[crs_pkg::PSW_I]  = 1'b0;
      pswNext[crs_pkg::PSW_U]  = 1'b0;
      pswNext[crs_pkg::PSW_PM] = 1'b0;
    end
    // one context only: a nested fast entry overwrites it
    if (takeIrq && irqFast) begin
      fspcNext = curPc;
      fsstNext = pswReg;
    end
    rdNext = pswReg;
    case (crs_pkg::crs_ctrl_sel_t'(ctrlSel))
      crs_pkg::CRS_CR_PSW:  rdNext = pswReg;
      crs_pkg::CRS_CR_USP:  rdNext = selUser ? gpr.spValue : uspReg;
      crs_pkg::CRS_CR_ISP:  rdNext = selUser ? ispReg : gpr.spValue;
      crs_pkg::CRS_CR_VTB:  rdNext = vtbReg;
      crs_pkg::CRS_CR_FLOAT_STATUS_WORD: rdNext = fpswReg;
      crs_pkg::CRS_CR_FVA:  rdNext = fvaReg;
      crs_pkg::CRS_CR_FSPC: rdNext = fspcReg;
      crs_pkg::CRS_CR_FSST: rdNext = fsstReg;
      default:              rdNext = pswReg;
    endcase
    // stack pointer banking, same process so each next value has one writer:
    // the idle pointer lives in its shadow, slot zero holds the active one,
    // so a control write to the active pointer must land in slot zero
    swapSp = pswNext[crs_pkg::PSW_U] != selUser;
    liveWr = ctrlWrEn && (selUser ? (ctrlSel == crs_pkg::CRS_CR_USP)
                                  : (ctrlSel == crs_pkg::CRS_CR_ISP));
    gpr.wrEn   = gprWrEn || spWrEn || liveWr || swapSp;
    gpr.wrIdx  = gprWrIdx;
    gpr.wrData = gprWrData;
    gpr.rdIdx  = gprRdIdx;
    if (liveWr) begin
      gpr.wrIdx  = 4'h0;
      gpr.wrData = ctrlWrData;
    end
    if (spWrEn) begin
      gpr.wrIdx  = 4'h0;
      gpr.wrData = spWrData;
    end
    // outgoing pointer keeps a write that lands in slot zero this cycle
    spOut = ((gprWrEn || spWrEn || liveWr) && gpr.wrIdx == 4'h0) ? gpr.wrData
                                                                  : gpr.spValue;
    if (swapSp) begin
      gpr.wrIdx  = 4'h0;
      gpr.wrData = pswNext[crs_pkg::PSW_U] ? uspNext : ispNext;
      if (selUser) begin
        uspNext = spOut;
      end else begin
        ispNext = spOut;
      end
    end
  end

  // ************************************************
  // event outputs
  // ************************************************
  always_comb begin
    accNext   = takeIrq;
    accFNext  = takeIrq && irqFast;
    fexNext   = floatOverflow && fpswReg[crs_pkg::FLOAT_STATUS_WORD_OVE];
    pcLdNext  = (takeIrq && irqFast) || fastReturn;
    pcValNext = fastReturn ? fspcReg : fvaReg;
    if (takeIrq && irqFast) begin
      pcValNext = fvaReg;
    end
  end

  // register only
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pswReg   <= crs_pkg::PSW_RESET;
      uspReg   <= crs_pkg::WORD_RESET;
      ispReg   <= crs_pkg::WORD_RESET;
      vtbReg   <= crs_pkg::WORD_RESET;
      fpswReg  <= crs_pkg::FLOAT_STATUS_WORD_RESET;
      fvaReg   <= crs_pkg::WORD_RESET;
      fspcReg  <= crs_pkg::WORD_RESET;
      fsstReg  <= crs_pkg::WORD_RESET;
      accReg   <= 1'b0;
      accFReg  <= 1'b0;
      fexReg   <= 1'b0;
      pcLdReg  <= 1'b0;
      pcValReg <= crs_pkg::WORD_RESET;
      rdReg    <= crs_pkg::WORD_RESET;
    end else begin
      pswReg   <= pswNext;
      uspReg   <= uspNext;
      ispReg   <= ispNext;
      vtbReg   <= vtbNext;
      fpswReg  <= fpswNext;
      fvaReg   <= fvaNext;
      fspcReg  <= fspcNext;
      fsstReg  <= fsstNext;
      accReg   <= accNext;
      accFReg  <= accFNext;
      fexReg   <= fexNext;
      pcLdReg  <= pcLdNext;
      pcValReg <= pcValNext;
      rdReg    <= rdNext;
    end
  end

  // ************************************************
  // checks
  // ************************************************
  irq_gate_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    irqAccept |-> $past(irqLevel) > $past(pswReg[27:24]) && $past(pswReg[16]))
    else $error("irq accepted at or below mask");
  entry_clr_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    excAccept |=> !pswReg[16] && !pswReg[17] && !pswReg[20])
    else $error("entry left status bits set");
  fast_save_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (takeIrq && irqFast) |=> fspcReg == $past(curPc) && fsstReg == $past(pswReg))
    else $error("fast context not saved");
  fast_vec_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (takeIrq && irqFast) |=> pcLoadEn && pcLoadValue == $past(fvaReg))
    else $error("fast vector not loaded");
  fast_ret_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (fastReturn && !entry) |=> pswReg == $past(fsstReg) && pcLoadValue == $past(fspcReg))
    else $error("fast return not restored");
  float_ov_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    floatOverflow |=> fpswReg[2])
    else $error("float overflow not flagged");
  float_exc_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    floatException == $past(floatOverflow && fpswReg[10]))
    else $error("float exception mismatch");
  flag_upd_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (flagWrEn && !entry && !fastReturn) |=> pswReg[3:0] == $past(flagIn))
    else $error("flags not updated");

  // outputs straight from flops
  assign gprRdData           = gpr.rdData;
  assign stackPointer        = gpr.spValue;
  assign ctrlRdData          = rdReg;
  assign floatException      = fexReg;
  assign irqAccept           = accReg;
  assign irqAcceptFast       = accFReg;
  assign pcLoadEn            = pcLdReg;
  assign pcLoadValue         = pcValReg;
  assign processorStatusWord = pswReg;
  assign vectorTableBase     = vtbReg;
endmodule

// ### test/crs_irq_model.sv
// crs_irq_model: interrupt controller stand-in facing the cpu register set
// assumes: shares clk_sys and arst_n with crs_register_set; bench commands it
`timescale 1ns/1ns
module crs_irq_model (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  // bench commands
  input  wire logic       reqGo,
  input  wire logic       reqDrop,
  input  wire logic [3:0] reqLevel,
  input  wire logic       reqFast,
  // register set side
  input  wire logic       irqAccept,
  output logic            irqReq,
  output logic      [3:0] irqLevel,
  output logic            irqFast
);
  // ************************************************
  // request holding
  // ************************************************
  // request stays up as a level until taken or withdrawn, as a real
  // controller would; a released level shows the inverse, not the old value
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irqReq   <= 1'b0;
      irqLevel <= 4'h0;
      irqFast  <= 1'b0;
    end else if (reqGo) begin
      irqReq   <= 1'b1;
      irqLevel <= reqLevel;
      irqFast  <= reqFast;
    end else if (irqAccept || reqDrop) begin
      irqReq   <= 1'b0;
      irqLevel <= ~irqLevel;
      irqFast  <= ~irqFast;
    end
  end
endmodule

// ### test/crs_register_set_tb.sv
// crs_register_set_tb: self-checking bench for the cpu register set
// assumes: crs_irq_model plays the interrupt controller; bench plays datapath
`timescale 1ns/1ns
module crs_register_set_tb;
  // ************************************************
  // signals
  // ************************************************
  logic        clk_sys, arst_n;                       // clock, reset
  logic        gprWrEn, spWrEn, ctrlWrEn, flagWrEn;   // write strobes
  logic [3:0]  gprWrIdx, gprRdIdx, flagIn, irqLevel, reqLevel;
  logic [31:0] gprWrData, gprRdData, spWrData, stackPointer;
  logic [2:0]  ctrlSel;                               // control selector
  logic [31:0] ctrlWrData, ctrlRdData, curPc, pcLoadValue;
  logic [31:0] processorStatusWord, vectorTableBase;
  logic        floatOverflow, floatException, irqReq, irqFast;
  logic        irqAccept, irqAcceptFast, excAccept, fastReturn, pcLoadEn;
  logic        reqGo, reqDrop, reqFast;               // model commands
  logic [2:0]  hitFlags;                              // accept, fast, load
  logic [31:0] pcSeen, pswSeen;                       // captured at accept
  int          n_errors, comparisons, cycles, i;      // bookkeeping
  // ************************************************
  // instances
  // ************************************************
  crs_register_set crs_register_set_i (.clk_sys, .arst_n, .gprWrEn, .gprWrIdx,
    .gprWrData, .gprRdIdx, .gprRdData, .spWrEn, .spWrData, .stackPointer,
    .ctrlWrEn, .ctrlSel, .ctrlWrData, .ctrlRdData, .flagWrEn, .flagIn,
    .floatOverflow, .floatException, .irqReq, .irqLevel, .irqFast, .irqAccept,
    .irqAcceptFast, .excAccept, .curPc, .fastReturn, .pcLoadEn, .pcLoadValue,
    .processorStatusWord, .vectorTableBase);
  crs_irq_model crs_irq_model_i (.clk_sys, .arst_n, .reqGo, .reqDrop, .reqLevel,
    .reqFast, .irqAccept, .irqReq, .irqLevel, .irqFast);
  // ************************************************
  // clock and watchdog
  // ************************************************
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // whole run needs about a hundred cycles; ceiling leaves wide margin
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles >= 3000) begin
      n_errors = n_errors + 1;
      final_report();
    end
  end
  // ************************************************
  // tasks
  // ************************************************
  // one compare, counted; mismatch reported at once
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // control write; idle edge after so calls can follow one another
  task automatic ctrlWr(input logic [2:0] s, input logic [31:0] d);
    ctrlWrEn = 1'b1;
    ctrlSel = s;
    ctrlWrData = d;
    @(negedge clk_sys);
    ctrlWrEn = 1'b0;
    @(negedge clk_sys);
  endtask
  // control read: selection shows one edge later
  task automatic ctrlRd(input logic [2:0] s, input logic [31:0] exp);
    ctrlSel = s;
    @(negedge clk_sys);
    chk(ctrlRdData, exp);
  endtask
  // raise a request through the model, watch a bounded window for accept
  task automatic irqTry(input logic [3:0] lvl, input logic fst);
    hitFlags = 3'b000;
    reqGo = 1'b1;
    reqLevel = lvl;
    reqFast = fst;
    @(negedge clk_sys);
    reqGo = 1'b0;
    repeat (4) begin
      @(negedge clk_sys);
      if (irqAccept === 1'b1) begin
        hitFlags = {irqAccept, irqAcceptFast, pcLoadEn};
        pcSeen = pcLoadValue;
        pswSeen = processorStatusWord;
      end
    end
    reqDrop = 1'b1;
    @(negedge clk_sys);
    reqDrop = 1'b0;
  endtask
  // verdict, the only end of the run
  task automatic final_report();
    $display("errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    {n_errors, comparisons, cycles} = '0;
    {gprWrEn, spWrEn, ctrlWrEn, flagWrEn, floatOverflow, excAccept} = '0;
    {fastReturn, reqGo, reqDrop, reqFast, hitFlags, ctrlSel} = '0;
    {gprWrIdx, gprRdIdx, flagIn, reqLevel} = '0;
    {gprWrData, spWrData, ctrlWrData, curPc, pcSeen, pswSeen} = '0;
    arst_n = 1'b0;
    repeat (5) @(negedge clk_sys);
    arst_n = 1'b1;
    chk(processorStatusWord, 32'h0000_0000);
    ctrlRd(crs_pkg::CRS_CR_FLOAT_STATUS_WORD, 32'h0000_0100);
    irqTry(4'hf, 1'b0); // enable still low at top level
    chk(32'(hitFlags), 32'h0000_0000);
    // back-to-back writes of general registers one to fifteen, then read back
    gprWrEn = 1'b1;
    for (i = 1; i < 16; i++) begin
      gprWrIdx = 4'(i);
      gprWrData = 32'(i) * 32'h0101_0101;
      @(negedge clk_sys);
    end
    gprWrEn = 1'b0;
    for (i = 1; i < 16; i++) begin
      gprRdIdx = 4'(i);
      @(negedge clk_sys);
      chk(gprRdData, 32'(i) * 32'h0101_0101);
    end
    // stack pointer lives in slot zero, banked by the select bit
    spWrEn = 1'b1;
    spWrData = 32'h0000_00a0;
    gprRdIdx = 4'h0;
    @(negedge clk_sys);
    spWrEn = 1'b0;
    chk(stackPointer, 32'h0000_00a0);
    @(negedge clk_sys);
    chk(gprRdData, 32'h0000_00a0);
    ctrlRd(crs_pkg::CRS_CR_ISP, 32'h0000_00a0);
    ctrlWr(crs_pkg::CRS_CR_USP, 32'h0000_00b0);
    chk(stackPointer, 32'h0000_00a0);
    ctrlWr(crs_pkg::CRS_CR_VTB, 32'h0000_8000);
    chk(vectorTableBase, 32'h0000_8000);
    ctrlWr(crs_pkg::CRS_CR_PSW, 32'h0513_0000); // mask 5, enable, user stack
    chk(stackPointer, 32'h0000_00b0);
    ctrlWr(crs_pkg::CRS_CR_USP, 32'h0000_00c0); // write to the live pointer
    chk(stackPointer, 32'h0000_00c0);
    irqTry(4'h5, 1'b0); // equal to mask: refused
    chk(32'(hitFlags), 32'h0000_0000);
    irqTry(4'h6, 1'b0);
    chk(32'(hitFlags[2:1]), 32'h0000_0002);
    chk(pswSeen, 32'h0500_0000);
    chk(stackPointer, 32'h0000_00a0);
    // fast entry, then a nested one overwriting the single saved context
    ctrlWr(crs_pkg::CRS_CR_FVA, 32'h0000_0400);
    ctrlWr(crs_pkg::CRS_CR_PSW, 32'h0513_0000);
    curPc = 32'h0000_1234;
    irqTry(4'h7, 1'b1);
    chk(32'(hitFlags), 32'h0000_0007);
    chk(pcSeen, 32'h0000_0400);
    ctrlRd(crs_pkg::CRS_CR_FSPC, 32'h0000_1234);
    ctrlRd(crs_pkg::CRS_CR_FSST, 32'h0513_0000);
    ctrlWr(crs_pkg::CRS_CR_PSW, 32'h0501_0000);
    curPc = 32'h0000_5678;
    irqTry(4'h9, 1'b1);
    ctrlRd(crs_pkg::CRS_CR_FSPC, 32'h0000_5678);
    ctrlRd(crs_pkg::CRS_CR_FSST, 32'h0501_0000);
    fastReturn = 1'b1;
    @(negedge clk_sys);
    fastReturn = 1'b0;
    pcSeen = '0;
    repeat (3) begin
      if (pcLoadEn === 1'b1) pcSeen = pcLoadValue;
      @(negedge clk_sys);
    end
    chk(pcSeen, 32'h0000_5678);
    chk(processorStatusWord, 32'h0501_0000);
    // other exception entry clears enable, stack select and mode
    ctrlWr(crs_pkg::CRS_CR_PSW, 32'h0513_0000);
    excAccept = 1'b1;
    @(negedge clk_sys);
    excAccept = 1'b0;
    chk(processorStatusWord, 32'h0500_0000);
    // arithmetic flags, carry set then clear, back to back
    flagWrEn = 1'b1;
    flagIn = 4'b1011;
    @(negedge clk_sys);
    chk(32'(processorStatusWord[3:0]), 32'h0000_000b);
    flagIn = 4'b0110;
    @(negedge clk_sys);
    flagWrEn = 1'b0;
    chk(32'(processorStatusWord[3:0]), 32'h0000_0006);
    // float overflow with trap off, then with trap on
    floatOverflow = 1'b1;
    @(negedge clk_sys);
    floatOverflow = 1'b0;
    chk(32'(floatException), 32'h0000_0000);
    ctrlRd(crs_pkg::CRS_CR_FLOAT_STATUS_WORD, 32'h0000_0104);
    ctrlWr(crs_pkg::CRS_CR_FLOAT_STATUS_WORD, 32'h0000_0400);
    floatOverflow = 1'b1;
    @(negedge clk_sys);
    floatOverflow = 1'b0;
    chk(32'(floatException), 32'h0000_0001);
    ctrlRd(crs_pkg::CRS_CR_FLOAT_STATUS_WORD, 32'h0000_0404);
    final_report();
  end
endmodule
